// ### shared/opt_pkg.sv
// Constants, register map and field layout of the output port and timer control block.
// How it works
// - Config bits 1:0 route output 2.
// - Config bits 3:2 route output 3.
// - All route fields default to latches.
// - Counter output low from terminal count until stop.
// - Bit 4 puts inverted flag 1 on output 4.
// - Bit 5 puts inverted flag 5 on output 5.
// - Bit 6 puts inverted flag 0 on output 6.
// - Bit 7 puts inverted flag 4 on output 7.
// - Reading start address starts counter/timer.
// - Reading stop address stops the counter in counter mode only.
// - Set-low write asserts outputs written one.
// - Asserted output stays low until set-high.
// - Set-high write negates outputs written one.
// - Alternate outputs ignore latches; latches still update.
// - Command codes 8/9 drive request-to-send.
// - Timer mode stop only clears ready flag.
package opt_pkg;
    localparam int unsigned APB_AW = 8;
    localparam logic [7:0] OFS_ROUTE_CFG = 8'h00;
    localparam logic [7:0] OFS_TIMER_START = 8'h04;
    localparam logic [7:0] OFS_TIMER_STOP = 8'h08;
    localparam logic [7:0] OFS_SET_LOW = 8'h0C;
    localparam logic [7:0] OFS_SET_HIGH = 8'h10;
    localparam logic [7:0] OFS_AUX_CTRL = 8'h14;
    localparam logic [7:0] OFS_CHAN_A_CMD = 8'h18;
    localparam logic [7:0] OFS_ALT_SELECT = 8'h1C;
    localparam logic [7:0] OFS_PORT_STATUS = 8'h20;
    localparam int unsigned ROUTE_OP2_LSB = 0;
    localparam int unsigned ROUTE_OP3_LSB = 2;
    localparam int unsigned ROUTE_OP4_BIT = 4;
    localparam logic [1:0] SEL_LATCH = 2'h0;
    localparam logic [1:0] SEL_ALT1 = 2'h1;
    localparam logic [1:0] SEL_ALT2 = 2'h2;
    localparam logic [1:0] SEL_ALT3 = 2'h3;
    localparam int unsigned FLAG_TX_READY_A = 0;
    localparam int unsigned FLAG_RX_READY_A = 1;
    localparam int unsigned FLAG_TX_READY_B = 4;
    localparam int unsigned FLAG_RX_READY_B = 5;
    localparam int unsigned READY_FLAG_BIT [4] = '{FLAG_RX_READY_A, FLAG_RX_READY_B, FLAG_TX_READY_A, FLAG_TX_READY_B};
    localparam int unsigned AUX_TIMER_MODE_BIT = 6;
    localparam int unsigned ALT_RTS_BIT = 0;
    localparam int unsigned CMD_CODE_LSB = 4;
    localparam logic [3:0] CMD_RTS_ASSERT = 4'h8;
    localparam logic [3:0] CMD_RTS_NEGATE = 4'h9;
    localparam int unsigned PSTAT_CT_READY_BIT = 8;
    localparam int unsigned PSTAT_CT_RUN_BIT = 9;
    localparam int unsigned PSTAT_CT_OUT_BIT = 10;
    localparam logic [7:0] ROUTE_CFG_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] ALT_RESET = 8'h00;
    localparam logic [7:0] PINS_RESET = 8'hFF;
endpackage : opt_pkg

// ### shared/opt_route_if.sv
// Signals shared by the register logic, the output multiplexer and the timer control.
`timescale 1ns/1ns
interface opt_route_if;
    logic [7:0] route_cfg;
    logic [7:0] gp_asserted;
    logic rts_enable;
    logic rts_asserted;
    logic tx_a_clk16;
    logic tx_a_clk1;
    logic rx_a_clk1;
    logic tx_b_clk1;
    logic rx_b_clk1;
    logic [7:0] status_flags;
    logic start_cmd;
    logic stop_cmd;
    logic timer_mode;
    logic terminal_count;
    logic square_wave;
    logic ct_out;
    logic ct_ready;
    logic ct_running;
    logic [7:0] pins;
    modport regs (
        output route_cfg, gp_asserted, rts_enable, rts_asserted, tx_a_clk16, tx_a_clk1, rx_a_clk1,
        output tx_b_clk1, rx_b_clk1, status_flags, start_cmd, stop_cmd, timer_mode, terminal_count,
        output square_wave,
        input ct_out, ct_ready, ct_running, pins
    );
    modport mux (
        input route_cfg, gp_asserted, rts_enable, rts_asserted, tx_a_clk16, tx_a_clk1, rx_a_clk1,
        input tx_b_clk1, rx_b_clk1, status_flags, ct_out,
        output pins
    );
    modport timer (
        input start_cmd, stop_cmd, timer_mode, terminal_count, square_wave,
        output ct_out, ct_ready, ct_running
    );
endinterface : opt_route_if

// ### verilog/opt_out_mux.sv
// Output routing multiplexer with registered output pins.
`timescale 1ns/1ns
module opt_out_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    opt_route_if.mux route
);
    import opt_pkg::*;

    logic [7:0] next_pins;
    logic [7:0] pin_level;
    logic [3:0] ready_level;

    // Outputs 4 to 7 follow the inverted ready flags when their bit is set.
    for (genvar g = 0; g < 4; g++) begin : g_ready
        assign ready_level[g] = route.route_cfg[ROUTE_OP4_BIT + g] ?
            ~route.status_flags[READY_FLAG_BIT[g]] : ~route.gp_asserted[4 + g];
    end

    always_comb begin
        next_pins = ~route.gp_asserted;
        if (route.rts_enable) begin
            next_pins[0] = ~route.rts_asserted;
        end
        case (route.route_cfg[ROUTE_OP2_LSB +: 2])
            SEL_ALT1: next_pins[2] = route.tx_a_clk16;
            SEL_ALT2: next_pins[2] = route.tx_a_clk1;
            SEL_ALT3: next_pins[2] = route.rx_a_clk1;
            default: next_pins[2] = ~route.gp_asserted[2];
        endcase
        case (route.route_cfg[ROUTE_OP3_LSB +: 2])
            SEL_ALT1: next_pins[3] = route.ct_out;
            SEL_ALT2: next_pins[3] = route.tx_b_clk1;
            SEL_ALT3: next_pins[3] = route.rx_b_clk1;
            default: next_pins[3] = ~route.gp_asserted[3];
        endcase
        next_pins[7:4] = ready_level;
    end

    // Registering the pins adds one cycle to routed clocks but keeps the pads glitch free.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_level <= PINS_RESET;
        end else begin
            pin_level <= next_pins;
        end
    end

    assign route.pins = pin_level;
endmodule : opt_out_mux

// ### verilog/opt_timer_ctl.sv
// Start, stop, output level and ready flag of the counter/timer.
`timescale 1ns/1ns
module opt_timer_ctl (
    input wire logic clk_i,
    input wire logic rst_i,
    opt_route_if.timer ct
);
    import opt_pkg::*;

    logic wave_prev;
    logic out_level;
    logic ready;
    logic running;
    logic count_done;
    logic wave_rise;

    assign count_done = running & ~ct.timer_mode & ct.terminal_count;
    assign wave_rise = running & ct.timer_mode & ct.square_wave & ~wave_prev;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wave_prev <= 1'b0;
        end else begin
            wave_prev <= ct.square_wave;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            running <= 1'b0;
        end else if (ct.start_cmd) begin
            running <= 1'b1;
        end else if (ct.stop_cmd && !ct.timer_mode) begin
            running <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_level <= 1'b1;
        end else if (ct.timer_mode) begin
            out_level <= running ? ct.square_wave : 1'b1;
        end else if (ct.stop_cmd) begin
            out_level <= 1'b1;
        end else if (count_done) begin
            out_level <= 1'b0;
        end
    end

    // A new terminal count or rising edge wins over a stop in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready <= 1'b0;
        end else if (count_done || wave_rise) begin
            ready <= 1'b1;
        end else if (ct.stop_cmd) begin
            ready <= 1'b0;
        end
    end

    assign ct.ct_out = out_level;
    assign ct.ct_ready = ready;
    assign ct.ct_running = running;
endmodule : opt_timer_ctl

// ### verilog/opt_top.sv
// APB register front end, output latches and command decode of the output port block.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module opt_top #(
    parameter int unsigned ADDR_WIDTH = opt_pkg::APB_AW
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_WIDTH-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic chan_a_tx_clock_16x_i,
    input wire logic chan_a_tx_clock_1x_i,
    input wire logic chan_a_rx_clock_1x_i,
    input wire logic chan_b_tx_clock_1x_i,
    input wire logic chan_b_rx_clock_1x_i,
    input wire logic [7:0] interrupt_status_flags_i,
    input wire logic ct_terminal_count_i,
    input wire logic ct_square_wave_i,
    output logic [7:0] multi_output_o,
    output logic ct_start_o,
    output logic ct_stop_o,
    output logic ct_timer_mode_o,
    output logic ct_ready_o
);
    import opt_pkg::*;

    if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin : g_bad_width
        $error("opt_top: ADDR_WIDTH must lie between 6 and 32");
    end

    opt_route_if route ();

    logic [7:0] output_route_config;
    logic [7:0] gp_asserted;
    logic [7:0] auxiliary_control;
    logic [7:0] alt_select;
    logic rts_asserted;
    logic start_cmd;
    logic stop_cmd;
    logic [31:0] next_rdata;
    logic setup_rd;
    logic access;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [7:0] wbyte;
    logic [3:0] cmd_code;

    // Word offsets only; a misaligned address never matches.
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] ofs);
        hit = (addr == ADDR_WIDTH'(ofs));
    endfunction : hit

    function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] addr);
        is_mapped = hit(addr, OFS_ROUTE_CFG) | hit(addr, OFS_TIMER_START) | hit(addr, OFS_TIMER_STOP) |
            hit(addr, OFS_SET_LOW) | hit(addr, OFS_SET_HIGH) | hit(addr, OFS_AUX_CTRL) |
            hit(addr, OFS_CHAN_A_CMD) | hit(addr, OFS_ALT_SELECT) | hit(addr, OFS_PORT_STATUS);
    endfunction : is_mapped

    // The slave never inserts wait states, so every access phase completes at its first edge.
    assign access = psel_i & penable_i;
    assign mapped = is_mapped(paddr_i);
    assign wr_en = access & pwrite_i & mapped & pstrb_i[0];
    assign rd_en = access & ~pwrite_i & mapped;
    assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
    assign wbyte = pwdata_i[7:0];
    assign cmd_code = wbyte[CMD_CODE_LSB +: 4];
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~mapped;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_route_config <= ROUTE_CFG_RESET;
        end else if (wr_en && hit(paddr_i, OFS_ROUTE_CFG)) begin
            output_route_config <= wbyte;
        end
    end

    // Latches keep updating while their pin is routed elsewhere, so a later switch back shows the last write.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gp_asserted <= LATCH_RESET;
        end else if (wr_en && hit(paddr_i, OFS_SET_LOW)) begin
            gp_asserted <= gp_asserted | wbyte;
        end else if (wr_en && hit(paddr_i, OFS_SET_HIGH)) begin
            gp_asserted <= gp_asserted & ~wbyte;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            auxiliary_control <= AUX_RESET;
        end else if (wr_en && hit(paddr_i, OFS_AUX_CTRL)) begin
            auxiliary_control <= wbyte;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alt_select <= ALT_RESET;
        end else if (wr_en && hit(paddr_i, OFS_ALT_SELECT)) begin
            alt_select <= wbyte;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rts_asserted <= 1'b0;
        end else if (wr_en && hit(paddr_i, OFS_CHAN_A_CMD)) begin
            if (cmd_code == CMD_RTS_ASSERT) begin
                rts_asserted <= 1'b1;
            end else if (cmd_code == CMD_RTS_NEGATE) begin
                rts_asserted <= 1'b0;
            end
        end
    end

    // Command pulses come one cycle after the read completes; the read data itself carries nothing.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_cmd <= 1'b0;
            stop_cmd <= 1'b0;
        end else begin
            start_cmd <= rd_en & hit(paddr_i, OFS_TIMER_START);
            stop_cmd <= rd_en & hit(paddr_i, OFS_TIMER_STOP);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(paddr_i, OFS_AUX_CTRL)) begin
            next_rdata[7:0] = auxiliary_control;
        end else if (hit(paddr_i, OFS_ALT_SELECT)) begin
            next_rdata[7:0] = alt_select;
        end else if (hit(paddr_i, OFS_PORT_STATUS)) begin
            next_rdata[7:0] = route.pins;
            next_rdata[PSTAT_CT_READY_BIT] = route.ct_ready;
            next_rdata[PSTAT_CT_RUN_BIT] = route.ct_running;
            next_rdata[PSTAT_CT_OUT_BIT] = route.ct_out;
        end
    end

    // Read data is captured in the setup cycle so the zero-wait access phase presents a registered value.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_o <= next_rdata;
        end
    end

    assign route.route_cfg = output_route_config;
    assign route.gp_asserted = gp_asserted;
    assign route.rts_enable = alt_select[ALT_RTS_BIT];
    assign route.rts_asserted = rts_asserted;
    assign route.tx_a_clk16 = chan_a_tx_clock_16x_i;
    assign route.tx_a_clk1 = chan_a_tx_clock_1x_i;
    assign route.rx_a_clk1 = chan_a_rx_clock_1x_i;
    assign route.tx_b_clk1 = chan_b_tx_clock_1x_i;
    assign route.rx_b_clk1 = chan_b_rx_clock_1x_i;
    assign route.status_flags = interrupt_status_flags_i;
    assign route.start_cmd = start_cmd;
    assign route.stop_cmd = stop_cmd;
    assign route.timer_mode = auxiliary_control[AUX_TIMER_MODE_BIT];
    assign route.terminal_count = ct_terminal_count_i;
    assign route.square_wave = ct_square_wave_i;

    opt_out_mux u_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .route(route.mux)
    );

    opt_timer_ctl u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ct(route.timer)
    );

    assign multi_output_o = route.pins;
    assign ct_start_o = start_cmd;
    assign ct_stop_o = stop_cmd;
    assign ct_timer_mode_o = auxiliary_control[AUX_TIMER_MODE_BIT];
    assign ct_ready_o = route.ct_ready;
endmodule : opt_top

// ### dv/opt_top_props.sv
// Concurrent checks on the ports of the output port block.
`timescale 1ns/1ns
module opt_top_props #(
    parameter int unsigned ADDR_WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_WIDTH-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [7:0] multi_output_o,
    input wire logic ct_start_o,
    input wire logic ct_stop_o,
    input wire logic ct_timer_mode_o
);
    import opt_pkg::*;
    logic rd_go;
    logic wr_go;
    assign rd_go = psel_i && penable_i && !pwrite_i;
    assign wr_go = psel_i && penable_i && pwrite_i && pstrb_i[0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_start_pulse: assert property (rd_go && paddr_i == OFS_TIMER_START |=> ct_start_o ##1 !ct_start_o)
        else $error("start read gave no single start pulse");
    a_start_cause: assert property ($rose(ct_start_o) |-> $past(rd_go && paddr_i == OFS_TIMER_START))
        else $error("start pulse without a start read");
    a_stop_pulse: assert property (rd_go && paddr_i == OFS_TIMER_STOP |=> ct_stop_o ##1 !ct_stop_o)
        else $error("stop read gave no single stop pulse");
    a_stop_cause: assert property ($rose(ct_stop_o) |-> $past(rd_go && paddr_i == OFS_TIMER_STOP))
        else $error("stop pulse without a stop read");
    a_set_low_pin: assert property (wr_go && paddr_i == OFS_SET_LOW && pwdata_i[1] |-> ##2 !multi_output_o[1])
        else $error("set-low write left output 1 high");
    a_set_high_pin: assert property (wr_go && paddr_i == OFS_SET_HIGH && pwdata_i[1] |-> ##2 multi_output_o[1])
        else $error("set-high write left output 1 low");
    a_pin_hold: assert property ($changed(multi_output_o[1]) |->
        $past(wr_go && (paddr_i == OFS_SET_LOW || paddr_i == OFS_SET_HIGH), 2))
        else $error("output 1 moved without a latch write");
    a_mode_follow: assert property (wr_go && paddr_i == OFS_AUX_CTRL |=>
        ct_timer_mode_o == $past(pwdata_i[AUX_TIMER_MODE_BIT]))
        else $error("timer mode does not follow the control write");
endmodule : opt_top_props

// ### dv/opt_host_model.sv
// Host CPU model: an APB master whose register cycles the testbench calls.
`timescale 1ns/1ns
module opt_host_model (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o
);
    initial begin
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
    end
    // Read data of the start and stop addresses is handed back but never judged by callers.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : opt_host_model

// ### dv/test_output_port_and_timer_control.sv
// Self-checking testbench of the output port block with random and corner stimulus.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module test_output_port_and_timer_control;
    import opt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, ct_start, ct_stop, ct_mode, ct_ready, alt, rts, e;
    logic tc = 1'b0;
    logic sq = 1'b0;
    logic [7:0] paddr, pins, lat, cfg;
    logic [7:0] flags = 8'h00;
    logic [4:0] clks = 5'h00;
    logic [31:0] pwdata, prdata, q, r;
    logic [3:0] pstrb;
    int miscompares = 0;
    int n_tests = 0;
    initial forever #4 clk_i = ~clk_i;
    opt_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .chan_a_tx_clock_16x_i(clks[0]), .chan_a_tx_clock_1x_i(clks[1]),
        .chan_a_rx_clock_1x_i(clks[2]), .chan_b_tx_clock_1x_i(clks[3]), .chan_b_rx_clock_1x_i(clks[4]),
        .interrupt_status_flags_i(flags), .ct_terminal_count_i(tc), .ct_square_wave_i(sq),
        .multi_output_o(pins), .ct_start_o(ct_start), .ct_stop_o(ct_stop), .ct_timer_mode_o(ct_mode),
        .ct_ready_o(ct_ready));
    opt_host_model host (.clk_i(clk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .pstrb_o(pstrb));
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        host.xfer(1'b1, a, {24'h000000, d}, s, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h00000000, 4'h0, q, e);
    endtask : rd
    // Pins are registered behind registered sources, so three edges cover every path.
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle
    function automatic logic [7:0] exp_pins(input logic ct);
        logic [7:0] p;
        p = ~lat;
        if (alt) p[0] = ~rts;
        if (cfg[1:0] != 2'h0) p[2] = clks[cfg[1:0] - 1];
        if (cfg[3:2] == 2'h1) p[3] = ct;
        if (cfg[3:2] > 2'h1) p[3] = clks[cfg[3:2] + 1];
        for (int i = 0; i < 4; i++) if (cfg[4 + i]) p[4 + i] = ~flags[READY_FLAG_BIT[i]];
        return p;
    endfunction : exp_pins
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(32'h0a75bee7));
        {lat, cfg, alt, rts} = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        `CHK(pins, 8'hFF)
        `CHK({ct_ready, ct_mode}, 2'h0)
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            wr(r[12] ? OFS_SET_LOW : OFS_SET_HIGH, r[7:0], r[11:8]);
            if (r[8]) lat = r[12] ? (lat | r[7:0]) : (lat & ~r[7:0]);
            settle();
            `CHK(pins, exp_pins(1'b1))
        end
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            @(posedge clk_i);
            flags <= r[7:0];
            clks <= r[12:8];
            cfg = {r[19:16], i[3:0]};
            wr(OFS_ROUTE_CFG, cfg, 4'hF);
            wr(OFS_SET_LOW, r[27:20], 4'hF);
            lat = lat | r[27:20];
            settle();
            `CHK(pins, exp_pins(1'b1))
        end
        wr(OFS_ALT_SELECT, 8'h01, 4'hF);
        alt = 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CHAN_A_CMD, i[0] ? 8'h90 : 8'h80, 4'hF);
            wr(i[0] ? OFS_SET_LOW : OFS_SET_HIGH, 8'h01, 4'hF);
            rts = ~i[0];
            lat[0] = i[0];
            settle();
            `CHK(pins, exp_pins(1'b1))
        end
        cfg = 8'h04;
        wr(OFS_ROUTE_CFG, cfg, 4'hF);
        rd(OFS_TIMER_START);
        rd(OFS_PORT_STATUS);
        `CHK(q[10:8], 3'h6)
        @(posedge clk_i);
        tc <= 1'b1;
        @(posedge clk_i);
        tc <= 1'b0;
        settle();
        `CHK({pins, ct_ready}, {exp_pins(1'b0), 1'b1})
        rd(OFS_TIMER_STOP);
        settle();
        `CHK({pins, ct_ready}, {exp_pins(1'b1), 1'b0})
        rd(OFS_PORT_STATUS);
        `CHK(q[10:8], 3'h4)
        cfg = 8'h00;
        wr(OFS_ROUTE_CFG, cfg, 4'hF);
        wr(OFS_AUX_CTRL, 8'h40, 4'hF);
        rd(OFS_AUX_CTRL);
        `CHK(q, 32'h00000040)
        rd(OFS_TIMER_START);
        @(posedge clk_i);
        sq <= 1'b1;
        settle();
        `CHK(ct_ready, 1'b1)
        `CHK(pins, exp_pins(1'b1))
        rd(OFS_TIMER_STOP);
        settle();
        `CHK(ct_ready, 1'b0)
        rd(OFS_PORT_STATUS);
        `CHK(q[10:8], 3'h6)
        cfg = 8'h04;
        wr(OFS_ROUTE_CFG, cfg, 4'hF);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            sq <= i[0];
            settle();
            `CHK(pins[3], i[0])
        end
        rd(8'h24);
        `CHK({e, q}, {1'b1, 32'h00000000})
        settle();
        `CHK(pins, exp_pins(1'b1))
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        `CHK({pins, ct_mode}, {8'hFF, 1'b0})
        @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        `CHK({pins, ct_ready}, {8'hFF, 1'b0})
        final_report();
    end
endmodule : test_output_port_and_timer_control
bind opt_top opt_top_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .multi_output_o(multi_output_o), .ct_start_o(ct_start_o), .ct_stop_o(ct_stop_o),
    .ct_timer_mode_o(ct_timer_mode_o));
